/* rtl/cap_consts.svh */
`ifndef CAP_CONSTS_SVH
`define CAP_CONSTS_SVH
// Overview of operation
// R01 - a function code with bad odd parity returns parity error and illegal
// R02 - an address or data word with bad odd parity returns parity error only
// R03 - each memory word handed out in a block read is parity checked
// R04 - a memory parity error sets the host status bit and latches the bank
// R05 - a memory parity error does not stop the block read
// R06 - after any parity error new operation codes are refused until end or clear
// R07 - a new write or read code ends the running operation
// R08 - remote end stores its message in buffer memory before interrupting
// R09 - remote interrupt is held in a status bit until the host clears it
// R10 - select bits pick one of eight ports, high bit picks port 1
// R11 - the group is connected while the connect nibble holds 3
// R12 - setting then clearing the clear-interrupt bit drops the interrupt bit
// R13 - setting then clearing program clear resets mode, error bit and bank
// R14 - two command bits carry the control code sent to the remote end
// R15 - raising the strobe bit sends the held control code once
// R16 - status word shows coupler and per-port memory parity error bits
// R17 - status shows the selected port bank count in three bits
// R18 - the coupler variant acts like a port but sends no control code
// R19 - block read returns sequential words while the remote end requests
// R20 - write stores received words in sequential locations
// R21 - remote end moves blocks in whole pairs of 16-bit words
// R22 - the coupler variant shows the host parity status only
// R23 - decode write, read, data, null and end codes; 110 answers illegal
// R24 - remote end pairs every word with a function code in fixed order
// R25 - the word address comes from the second address word, 14 bits
// R26 - odd parity holds when the count of ones with parity bit is odd
// R27 - command words are dropped while the group is not connected
`define CAP_F_WRITE 3'h2
`define CAP_F_BREAD 3'h5
`define CAP_F_READ 3'h1
`define CAP_F_DATA 3'h4
`define CAP_F_NULL 3'h0
`define CAP_F_EOP 3'h7
`define CAP_F_ILL 3'h6
`define CAP_CONNECT 4'h3
// host words count bit 0 as the msb; the indices here are lsb based
`define CAP_SEL_BASE 7
`define CAP_CMD_CLRI 4
`define CAP_CMD_PCLR 3
`define CAP_CMD_CODE 1
`define CAP_CMD_STRB 0
`define CAP_ST_CPLR 15
`define CAP_ST_BANK 12
`define CAP_ADDR_W 14
`define CAP_FIFO_D 8
`endif

/* rtl/cap_pkg.sv */
package cap_pkg;
  typedef enum logic [1:0] {
    CAP_IDLE = 2'h0,
    CAP_ADDR = 2'h1,
    CAP_WR   = 2'h3,
    CAP_RD   = 2'h2
  } cap_state_t;
  // one word from the remote end, plus its request and interrupt lines
  typedef struct packed {
    logic        valid;
    logic [2:0]  func;
    logic        fpar;
    logic [15:0] data;
    logic        dpar;
    logic        rd_ready;
    logic        intr;
  } cap_chin_t;
  typedef struct packed {
    logic        rd_valid;
    logic [15:0] rd_data;
    logic        rd_par;
    logic        par_err;
    logic        illegal;
    logic [1:0]  ctl_code;
    logic        ctl_strobe;
  } cap_chout_t;
  typedef struct packed {
    logic [2:0]  bank;
    logic        par;
    logic [15:0] data;
  } cap_rdw_t;
  typedef struct packed {
    cap_state_t  st;
    logic        wr_op;
    logic [13:0] addr;
    logic        half;
    logic [14:0] rd_ptr;
    logic        lock;
    logic [15:0] sel;
    logic [15:0] cmd;
    logic        mem_err;
    logic [2:0]  bank;
    logic        intr;
    logic        par_err;
    logic        illegal;
    logic [1:0]  ctl_code;
    logic        ctl_strb;
    logic [15:0] status;
  } cap_core_t;
endpackage

/* rtl/cap_port.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cap_consts.svh"

module cap_fifo #(
  parameter int W = 20,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  import cap_pkg::*;
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } cap_fifo_t;
  cap_fifo_t f_reg;
  cap_fifo_t f_next;
  logic      push;
  logic      pop;

  // pointer step with wrap, depth need not be a power of two
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  // handshakes straight from the count
  assign in_ready  = f_reg.cnt != (AW+1)'(D);
  assign out_valid = f_reg.cnt != '0;
  assign out_data  = f_reg.mem[f_reg.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // flush wins over push so prefetched words of an old block never leak
  always_comb begin
    f_next = f_reg;
    if (flush) begin
      f_next.wp  = '0;
      f_next.rp  = '0;
      f_next.cnt = '0;
    end else begin
      if (push) begin
        f_next.mem[f_reg.wp] = in_data;
        f_next.wp = bump(f_reg.wp);
      end
      if (pop) begin
        f_next.rp = bump(f_reg.rp);
      end
      f_next.cnt = f_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end
endmodule

module cap_port #(
  parameter bit IS_CPLR  = 1'b0,
  parameter int PORT_NUM = 1,
  parameter int FIFO_D   = `CAP_FIFO_D
) (
  input  wire logic                core_clk,
  input  wire logic                reset,
  input  wire cap_pkg::cap_chin_t  chin,
  output var  cap_pkg::cap_chout_t chout,
  input  wire logic                host_sel_wr,
  input  wire logic                host_cmd_wr,
  input  wire logic [15:0]         host_wdata,
  output logic [15:0]              parity_status_word,
  output logic                     remote_intr_status
);
  import cap_pkg::*;
  localparam int MAW = `CAP_ADDR_W + 1;
  localparam int SEL_IDX = IS_CPLR ? `CAP_SEL_BASE : `CAP_SEL_BASE + PORT_NUM;
  localparam int ST_IDX = IS_CPLR ? `CAP_ST_CPLR : PORT_NUM - 1;

  cap_core_t   s_reg;
  cap_core_t   s_next;
  logic [16:0] sbm [0:(2**MAW)-1];
  logic        mem_we;
  logic [14:0] mem_wa;
  logic [16:0] mem_wd;
  logic        flush;
  logic        conn;
  logic        seld;
  logic        cmd_ok;
  logic        pclr;
  logic        clri;
  logic        strb;
  logic        fok;
  logic        dok;
  logic        dchk;
  logic        perr;
  logic        pop;
  logic        merr;
  logic        f_ir;
  logic        f_ov;
  cap_rdw_t    f_in;
  cap_rdw_t    f_out;
  logic [15:0] st_w;

  // codes that open a new transfer
  function automatic logic is_start(input logic [2:0] f);
    is_start = f == `CAP_F_WRITE || f == `CAP_F_BREAD || f == `CAP_F_READ;
  endfunction

  // codes whose word on the data path is an address or data word
  function automatic logic has_word(input logic [2:0] f);
    has_word = is_start(f) || f == `CAP_F_DATA || f == `CAP_F_NULL;
  endfunction

  // host side decode; select and command act only in the connected group
  assign conn   = s_reg.sel[3:0] == `CAP_CONNECT; // R11
  assign seld   = conn && s_reg.sel[SEL_IDX]; // R10
  assign cmd_ok = host_cmd_wr && conn; // R27
  // clear actions fire on the falling edge of their bit
  assign pclr = cmd_ok && seld && s_reg.cmd[`CAP_CMD_PCLR]
                && !host_wdata[`CAP_CMD_PCLR]; // R13
  assign clri = cmd_ok && seld && !IS_CPLR && s_reg.cmd[`CAP_CMD_CLRI]
                && !host_wdata[`CAP_CMD_CLRI]; // R12
  // the coupler has no control code path at all
  assign strb = cmd_ok && seld && !IS_CPLR && !s_reg.cmd[`CAP_CMD_STRB]
                && host_wdata[`CAP_CMD_STRB]; // R15 R18

  // odd parity checks on what the remote end sends
  assign fok  = ^{chin.func, chin.fpar}; // R26
  assign dok  = ^{chin.data, chin.dpar}; // R26
  assign dchk = fok && has_word(chin.func);
  assign perr = chin.valid && (!fok || (dchk && !dok)); // R01 R02

  // read data leaves through the fifo; parity is judged as B takes it
  assign pop  = f_ov && chin.rd_ready;
  assign merr = pop && !(^{f_out.par, f_out.data}); // R03
  assign f_in = '{bank: s_reg.rd_ptr[MAW-1 -: 3],
                  par:  sbm[s_reg.rd_ptr][16],
                  data: sbm[s_reg.rd_ptr][15:0]};

  cap_fifo #(
    .W (20),
    .D (FIFO_D)
  ) u_rdq (
    .clk       (core_clk),
    .reset     (reset),
    .flush     (flush),
    .in_valid  (s_reg.st == CAP_RD),
    .in_ready  (f_ir),
    .in_data   (f_in),
    .out_valid (f_ov),
    .out_ready (chin.rd_ready),
    .out_data  (f_out)
  );

  // status word image; bank shows only for the selected port
  always_comb begin
    st_w = '0;
    st_w[ST_IDX] = s_reg.mem_err; // R16 R22
    if (seld) begin
      st_w[`CAP_ST_BANK +: 3] = s_reg.bank; // R17
    end
  end

  // main next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.par_err  = 1'b0;
    s_next.illegal  = 1'b0;
    s_next.ctl_strb = 1'b0;
    s_next.status   = st_w;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = '0;
    flush  = 1'b0;
    if (host_sel_wr) begin
      s_next.sel = host_wdata;
    end
    if (cmd_ok) begin
      s_next.cmd = host_wdata;
    end
    if (strb) begin
      s_next.ctl_code = host_wdata[`CAP_CMD_CODE +: 2]; // R14
      s_next.ctl_strb = 1'b1; // R15
    end
    // prefetch runs while the fifo has room, so B throttles memory reads
    if (s_reg.st == CAP_RD && f_ir) begin
      s_next.rd_ptr = 15'(s_reg.rd_ptr + 15'h1); // R19
    end
    if (chin.valid && !fok) begin
      s_next.par_err = 1'b1; // R01
      s_next.illegal = 1'b1; // R01
    end else if (chin.valid) begin
      if (dchk && !dok) begin
        s_next.par_err = 1'b1; // R02
      end
      case (chin.func)
        `CAP_F_WRITE, `CAP_F_BREAD, `CAP_F_READ: begin
          // a locked port ignores new work; running one carries on
          if (!s_reg.lock) begin // R06
            s_next.st    = CAP_ADDR; // R07
            s_next.wr_op = chin.func == `CAP_F_WRITE; // R23
            s_next.half  = 1'b0;
            flush = 1'b1; // R07
          end
        end
        `CAP_F_NULL: begin
          if (s_reg.st == CAP_ADDR) begin
            // first address word is dropped, the second holds the address
            s_next.addr   = chin.data[`CAP_ADDR_W-1:0]; // R25
            s_next.rd_ptr = {chin.data[`CAP_ADDR_W-1:0], 1'b0};
            s_next.st     = s_reg.wr_op ? CAP_WR : CAP_RD;
          end else if (s_reg.st == CAP_WR && s_reg.half) begin
            mem_we = 1'b1; // R20
            mem_wa = {s_reg.addr, 1'b1};
            mem_wd = {chin.dpar, chin.data};
            s_next.addr = 14'(s_reg.addr + 14'h1); // R20
            s_next.half = 1'b0;
          end
        end
        `CAP_F_DATA: begin
          // the data code carries the most significant half of the pair
          if (s_reg.st == CAP_WR) begin
            mem_we = 1'b1; // R20
            mem_wa = {s_reg.addr, 1'b0};
            mem_wd = {chin.dpar, chin.data};
            s_next.half = 1'b1;
          end
        end
        `CAP_F_EOP: begin
          s_next.st   = CAP_IDLE; // R23
          s_next.lock = 1'b0; // R06
          s_next.half = 1'b0;
          flush = 1'b1;
        end
        `CAP_F_ILL: begin
          s_next.illegal = 1'b1; // R23
        end
        default: begin
          // special function code has no meaning on this port
        end
      endcase
    end
    if (pclr) begin
      s_next.st      = CAP_IDLE; // R13
      s_next.wr_op   = 1'b0;
      s_next.half    = 1'b0;
      s_next.mem_err = 1'b0;
      s_next.bank    = '0;
      s_next.lock    = 1'b0;
      flush = 1'b1;
    end
    // errors are applied after the clears so a same-cycle event survives
    if (merr) begin
      s_next.par_err = 1'b1; // R03
      s_next.mem_err = 1'b1; // R04
      s_next.bank    = f_out.bank; // R04
    end
    if (perr || merr) begin
      s_next.lock = 1'b1; // R06
    end
    // interrupt request sets over a clear in the same cycle
    s_next.intr = !IS_CPLR && ((s_reg.intr && !clri) || chin.intr); // R09 R12
  end

  // buffer memory keeps the parity bit as received, so a bad word is caught on read
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      sbm[mem_wa] <= mem_wd;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // the block read is never stopped by an error here, only by B or a program clear
  always_comb begin
    chout.rd_valid   = f_ov; // R05
    chout.rd_data    = f_out.data;
    chout.rd_par     = f_out.par;
    chout.par_err    = s_reg.par_err;
    chout.illegal    = s_reg.illegal;
    chout.ctl_code   = IS_CPLR ? 2'h0 : s_reg.ctl_code; // R18
    chout.ctl_strobe = s_reg.ctl_strb;
  end
  assign parity_status_word = s_reg.status;
  assign remote_intr_status = s_reg.intr;

  property p_fpar;
    @(posedge core_clk) disable iff (reset)
    chin.valid && !fok |=> chout.par_err && chout.illegal;
  endproperty
  a_fpar: assert property (p_fpar) // R01
    else $error("function parity error not answered");

  property p_dpar;
    @(posedge core_clk) disable iff (reset)
    chin.valid && dchk && !dok |=> chout.par_err && !chout.illegal;
  endproperty
  a_dpar: assert property (p_dpar) // R02
    else $error("word parity error answered wrongly");

  property p_ill;
    @(posedge core_clk) disable iff (reset)
    chin.valid && fok && chin.func == `CAP_F_ILL |=> chout.illegal;
  endproperty
  a_ill: assert property (p_ill) // R23
    else $error("illegal code not answered");

  property p_merr;
    @(posedge core_clk) disable iff (reset)
    merr |=> chout.par_err && s_reg.mem_err && s_reg.bank == $past(f_out.bank);
  endproperty
  a_merr: assert property (p_merr) // R04
    else $error("memory parity error not recorded");

  property p_rdgo;
    @(posedge core_clk) disable iff (reset)
    s_reg.st == CAP_RD && merr && !chin.valid && !pclr |=> s_reg.st == CAP_RD;
  endproperty
  a_rdgo: assert property (p_rdgo) // R05
    else $error("block read stopped by parity error");

  // a refused start leaves whatever runs untouched, idle or mid-read alike
  property p_lock;
    @(posedge core_clk) disable iff (reset)
    s_reg.lock && chin.valid && fok && is_start(chin.func) && !pclr
      |=> s_reg.st == $past(s_reg.st) && s_reg.wr_op == $past(s_reg.wr_op);
  endproperty
  a_lock: assert property (p_lock) // R06
    else $error("new operation taken while locked");

  property p_newop;
    @(posedge core_clk) disable iff (reset)
    (s_reg.st == CAP_WR || s_reg.st == CAP_RD) && !s_reg.lock && chin.valid
      && fok && is_start(chin.func) && !pclr |=> s_reg.st == CAP_ADDR ##1 !f_ov;
  endproperty
  a_newop: assert property (p_newop) // R07
    else $error("new operation did not end the old one");

  property p_intr;
    @(posedge core_clk) disable iff (reset)
    chin.intr && !IS_CPLR ##1 !chin.intr && !clri |=> remote_intr_status;
  endproperty
  a_intr: assert property (p_intr) // R09
    else $error("remote interrupt not held");

  property p_nocon;
    @(posedge core_clk) disable iff (reset)
    host_cmd_wr && !conn |=> $stable(s_reg.cmd) && !chout.ctl_strobe;
  endproperty
  a_nocon: assert property (p_nocon) // R27
    else $error("command taken while not connected");

  property p_strb;
    @(posedge core_clk) disable iff (reset)
    strb |=> chout.ctl_strobe && chout.ctl_code == $past(host_wdata[2:1]);
  endproperty
  a_strb: assert property (p_strb) // R15
    else $error("control code not sent");

  property p_pclr;
    @(posedge core_clk) disable iff (reset)
    pclr && !merr |=> !s_reg.mem_err && s_reg.bank == 3'h0
      && s_reg.st == CAP_IDLE ##1 !parity_status_word[ST_IDX];
  endproperty
  a_pclr: assert property (p_pclr) // R13
    else $error("program clear incomplete");

  property p_wadr;
    @(posedge core_clk) disable iff (reset)
    s_reg.st == CAP_WR && s_reg.half && chin.valid && fok
      && chin.func == `CAP_F_NULL && !pclr |=> s_reg.addr == 14'($past(s_reg.addr) + 14'h1);
  endproperty
  a_wadr: assert property (p_wadr) // R20
    else $error("write address did not advance");

  property p_bank;
    @(posedge core_clk) disable iff (reset)
    !seld |=> parity_status_word[14:12] == 3'h0;
  endproperty
  a_bank: assert property (p_bank) // R17
    else $error("bank count shown by unselected port");
endmodule
`default_nettype wire

/* tb/cap_remote_model.sv */
`timescale 1ns/10ps
`default_nettype none
// far-end station: every 16-bit word goes out with a function code,
// and read words are pulled by holding the ready level
module cap_remote_model (
  input  wire logic                core_clk,
  output var  cap_pkg::cap_chin_t  chin,
  input  wire cap_pkg::cap_chout_t chout
);
  import cap_pkg::*;

  initial chin = '0;

  // one word then a released cycle; bad[1] spoils code parity, bad[0] word parity
  task automatic word(input logic [2:0] f, input logic [15:0] d,
                      input logic [1:0] bad, output logic [1:0] resp);
    @(negedge core_clk);
    chin.valid = 1'b1;
    chin.func  = f;
    chin.fpar  = ~^f ^ bad[1];
    chin.data  = d;
    chin.dpar  = ~^d ^ bad[0];
    @(negedge core_clk);
    chin.valid = 1'b0;
    // released lines flip so a stale value is never mistaken for a word
    chin.func  = ~f;
    chin.data  = ~d;
    resp = {chout.par_err, chout.illegal};
  endtask

  // pull one read word; ready stays up so pulls may run back to back
  task automatic take(output logic [16:0] w, output logic pe);
    int i;
    if (chin.rd_ready !== 1'b1) begin
      chin.rd_ready = 1'b1;
    end
    for (i = 0; i < 40 && chout.rd_valid !== 1'b1; i++) begin
      @(negedge core_clk);
    end
    w = {chout.rd_par, chout.rd_data};
    @(negedge core_clk);
    pe = chout.par_err;
  endtask

  // stop requesting: pauses the block read from this side; the read state runs on
  task automatic rd_off;
    chin.rd_ready = 1'b0;
  endtask

  // raised only after the message has been written to buffer memory
  task automatic intr_pulse;
    @(negedge core_clk);
    chin.intr = 1'b1;
    @(negedge core_clk);
    chin.intr = 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/cap_port_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cap_consts.svh"
module cap_port_tb;
  import cap_pkg::*;
  localparam logic [13:0] ADDR_A = 14'h0805; // bank field is 1
  logic        core_clk;
  logic        reset;
  logic        host_sel_wr;
  logic        host_cmd_wr;
  logic [15:0] host_wdata;
  logic [15:0] parity_status_word;
  logic        remote_intr_status;
  cap_chin_t   chin;
  cap_chout_t  chout;
  int          fails;
  int          n_tests;
  int          cycles;
  int          k;
  logic [1:0]  r;
  logic [16:0] w;
  logic        pe;
  logic [2:0]  so;
  cap_chin_t   c_chin;
  cap_chout_t  c_chout;
  logic [15:0] c_status;
  logic        c_intr;

  cap_port #(.IS_CPLR(1'b0), .PORT_NUM(1), .FIFO_D(`CAP_FIFO_D)) DUT (
    .core_clk(core_clk), .reset(reset), .chin(chin), .chout(chout),
    .host_sel_wr(host_sel_wr), .host_cmd_wr(host_cmd_wr), .host_wdata(host_wdata),
    .parity_status_word(parity_status_word), .remote_intr_status(remote_intr_status));
  cap_remote_model pm (.core_clk(core_clk), .chin(chin), .chout(chout));
  // coupler variant shares the host lines; select bit [7] reaches it
  cap_port #(.IS_CPLR(1'b1), .PORT_NUM(1), .FIFO_D(`CAP_FIFO_D)) cplr (
    .core_clk(core_clk), .reset(reset), .chin(c_chin), .chout(c_chout),
    .host_sel_wr(host_sel_wr), .host_cmd_wr(host_cmd_wr), .host_wdata(host_wdata),
    .parity_status_word(c_status), .remote_intr_status(c_intr));
  cap_remote_model pmc (.core_clk(core_clk), .chin(c_chin), .chout(c_chout));

  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  function automatic logic [15:0] pat(input int i);
    return 16'ha5c3 ^ 16'(i * 273);
  endfunction

  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED at %0t ns: %s", $time, msg);
    end
  endtask

  // one host output word; so holds the strobe and code seen a cycle later
  task automatic host(input logic cmd, input logic [15:0] d);
    @(negedge core_clk);
    host_sel_wr = ~cmd;
    host_cmd_wr = cmd;
    host_wdata  = d;
    @(negedge core_clk);
    host_sel_wr = 1'b0;
    host_cmd_wr = 1'b0;
    so = {chout.ctl_strobe, chout.ctl_code};
  endtask

  task automatic close_out;
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // whole run is well under a thousand cycles; a hang ends here
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      close_out();
    end
  end

  initial begin
    reset = 1'b1;
    host_sel_wr = 1'b0;
    host_cmd_wr = 1'b0;
    host_wdata = 16'h0000;
    fails = 0;
    n_tests = 0;
    cycles = 0;
    repeat (12) @(negedge core_clk);
    reset = 1'b0;
    chk({chout.rd_valid, chout.par_err, chout.illegal, chout.ctl_strobe} === 4'h0
        && parity_status_word === 16'h0000 && remote_intr_status === 1'b0, "reset");
    host(1'b0, 16'h0103);
    // ten words written; word 3 carries a bad parity bit and poisons its slot
    pm.word(`CAP_F_WRITE, 16'hffff, 2'b00, r); chk(r === 2'b00, "write code");
    pm.word(`CAP_F_NULL, {2'b00, ADDR_A}, 2'b00, r);
    for (k = 0; k < 10; k++) begin
      pm.word(k[0] ? `CAP_F_NULL : `CAP_F_DATA, pat(k), {1'b0, k == 3}, r);
      chk(r === {k == 3, 1'b0}, "data word answer");
    end
    pm.word(`CAP_F_EOP, 16'h0000, 2'b00, r);
    pm.word(`CAP_F_NULL, 16'h0000, 2'b00, r);
    pm.word(`CAP_F_NULL, 16'h0000, 2'b10, r); chk(r === 2'b11, "code parity");
    pm.word(`CAP_F_EOP, 16'h0000, 2'b00, r);
    pm.word(`CAP_F_ILL, 16'h0000, 2'b00, r); chk(r === 2'b01, "illegal code");
    // block read with the reader stalled so the prefetch buffer fills
    pm.word(`CAP_F_BREAD, 16'h1234, 2'b00, r);
    pm.word(`CAP_F_NULL, {2'b00, ADDR_A}, 2'b00, r);
    repeat (20) @(negedge core_clk);
    for (k = 0; k < 8; k++) begin
      pm.take(w, pe);
      chk(w[15:0] === pat(k) && pe === (k == 3), "read word");
    end
    pm.rd_off();
    repeat (2) @(negedge core_clk);
    chk(parity_status_word === 16'h1001, "error bit and bank");
    // locked: a new write is ignored and the read stream runs on
    pm.word(`CAP_F_WRITE, 16'h0000, 2'b00, r);
    pm.word(`CAP_F_NULL, 16'h0040, 2'b00, r);
    pm.take(w, pe);
    chk(w[15:0] === pat(8) && r === 2'b00, "start refused while locked");
    // second word keeps the block a whole pair
    pm.take(w, pe);
    pm.rd_off();
    chk(w[15:0] === pat(9) && pe === 1'b0, "read runs on while locked");
    host(1'b1, 16'h0008);
    host(1'b1, 16'h0000);
    repeat (2) @(negedge core_clk);
    chk(parity_status_word === 16'h0000 && chout.rd_valid === 1'b0, "program clear");
    // a read code ends the running write without an end code
    pm.word(`CAP_F_WRITE, 16'h0000, 2'b00, r);
    pm.word(`CAP_F_NULL, 16'h0020, 2'b00, r);
    pm.word(`CAP_F_DATA, 16'h3c3c, 2'b00, r);
    pm.word(`CAP_F_NULL, 16'hc3c3, 2'b00, r);
    pm.word(`CAP_F_READ, 16'h0000, 2'b00, r);
    pm.word(`CAP_F_NULL, 16'h0020, 2'b00, r);
    pm.take(w, pe); chk(w[15:0] === 16'h3c3c, "first word after switch");
    pm.take(w, pe); chk(w === {1'b1, 16'hc3c3}, "second word and parity");
    pm.rd_off();
    pm.word(`CAP_F_EOP, 16'h0000, 2'b00, r);
    pm.word(`CAP_F_NULL, 16'h0000, 2'b00, r);
    pm.intr_pulse();
    repeat (3) @(negedge core_clk);
    chk(remote_intr_status === 1'b1, "interrupt held");
    host(1'b1, 16'h0010);
    host(1'b1, 16'h0000);
    repeat (2) @(negedge core_clk);
    chk(remote_intr_status === 1'b0, "interrupt cleared");
    // every control code, strobed and then dropped
    for (k = 0; k < 4; k++) begin
      host(1'b1, {13'h0000, k[1:0], 1'b1}); chk(so === {1'b1, k[1:0]}, "code sent");
      host(1'b1, 16'h0000);
    end
    host(1'b0, 16'h0203);
    host(1'b1, 16'h0001); chk(so[2] === 1'b0, "other port selected");
    host(1'b1, 16'h0000);
    host(1'b0, 16'h0100);
    host(1'b1, 16'h0001); chk(so[2] === 1'b0, "group not connected");
    host(1'b0, 16'h0103);
    host(1'b1, 16'h0001); chk(so[2] === 1'b1, "reconnected");
    // coupler: a poisoned pair read back shows in status bit [15] with its bank
    pmc.word(`CAP_F_WRITE, 16'h0000, 2'b00, r);
    pmc.word(`CAP_F_NULL, 16'h0800, 2'b00, r);
    pmc.word(`CAP_F_DATA, 16'h1111, 2'b00, r);
    pmc.word(`CAP_F_NULL, 16'h2222, 2'b01, r);
    chk(r === 2'b10, "coupler word parity");
    pmc.word(`CAP_F_EOP, 16'h0000, 2'b00, r);
    pmc.word(`CAP_F_BREAD, 16'h0000, 2'b00, r);
    pmc.word(`CAP_F_NULL, 16'h0800, 2'b00, r);
    pmc.take(w, pe);
    chk(w[15:0] === 16'h1111 && pe === 1'b0, "coupler first word");
    pmc.take(w, pe);
    chk(w[15:0] === 16'h2222 && pe === 1'b1, "coupler memory parity");
    pmc.rd_off();
    pmc.word(`CAP_F_EOP, 16'h0000, 2'b00, r);
    pmc.word(`CAP_F_NULL, 16'h0000, 2'b00, r);
    host(1'b0, 16'h0083);
    repeat (2) @(negedge core_clk);
    chk(c_status === 16'h9000 && parity_status_word === 16'h0000, "coupler status");
    // bit 0 is dropped first so the next word has a rising strobe edge
    host(1'b1, 16'h0000);
    host(1'b1, 16'h0007);
    chk(c_chout.ctl_strobe === 1'b0 && c_chout.ctl_code === 2'h0, "coupler sends no code");
    pmc.intr_pulse();
    repeat (2) @(negedge core_clk);
    chk(c_intr === 1'b0, "coupler keeps no interrupt bit");
    host(1'b1, 16'h0008);
    host(1'b1, 16'h0000);
    repeat (2) @(negedge core_clk);
    chk(c_status === 16'h0000, "coupler program clear");
    close_out();
  end
endmodule
`default_nettype wire
